/* File: hdl/timer_with_shared_prescaler.sv */
// timer/counter with prescaler shared with the watchdog
`timescale 1ns/1ps
module timer_with_shared_prescaler (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic [6:0] i_reg_addr,
   input  wire logic       i_reg_wr,
   input  wire logic [7:0] i_reg_wdata,
   output logic      [7:0] o_reg_rdata,
   input  wire logic       i_config_wr,
   input  wire logic [5:0] i_config_wdata,
   input  wire logic       i_watchdog_clear_instr,
   input  wire logic       i_watchdog_tick,
   input  wire logic       i_ext_count_input,
   output logic            o_watchdog_timeout
);
   logic [5:0] config_q;
   logic [1:0] phase_q;
   logic       pin_s1_q;
   logic       pin_s2_q;
   logic       pin_prev_q;
   logic       samp_q;
   logic       samp_prev_q;
   logic [7:0] count_q;
   logic [1:0] inhibit_q;
   logic       wd_prev_q;
   logic       src_sel;
   logic       edge_sel;
   logic       to_watchdog;
   logic [2:0] ratio;
   logic       count_wr;
   logic       pin_edge;
   logic       ps_step;
   logic       ps_clear;
   logic [7:0] ps_count;
   logic       ps_out;
   logic       src_level;
   logic       inc_event;
   logic       wd_out;

   // phase decode helpers, not called; the prescaler, sampler and inhibit logic compare phase_q directly
   function automatic logic is_phase_two(input logic [1:0] ph);
      return ph == tmr_pkg::PHASE_TWO;
   endfunction

   function automatic logic is_phase_four(input logic [1:0] ph);
      return ph == tmr_pkg::PHASE_FOUR;
   endfunction

   // widths below are fixed by the eight-bit chain, three ratio bits and the two-bit inhibit and phase counters
   initial begin
      if (tmr_pkg::PRESCALE_W != 8) $error("prescaler must be 8 stages");
      if (tmr_pkg::RATIO_MSB != 2) $error("ratio field must be 3 bits");
      if (tmr_pkg::INHIBIT_CYCLES > 3) $error("inhibit count too large");
      if (tmr_pkg::PHASES != 4) $error("phase counter holds 4 phases");
   end

   assign src_sel     = config_q[tmr_pkg::SRC_SEL_BIT];
   assign edge_sel    = config_q[tmr_pkg::EDGE_SEL_BIT];
   assign to_watchdog = config_q[tmr_pkg::ASSIGN_BIT];
   assign ratio       = config_q[tmr_pkg::RATIO_MSB:0];
   assign count_wr    = i_reg_wr && (i_reg_addr == tmr_pkg::TIMER_COUNT_ADDR);

   // config is write-only, so no read path
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         config_q <= tmr_pkg::CONFIG_RESET;
      end else if (i_config_wr) begin
         config_q <= i_config_wdata;
      end
   end

   // four internal phases per instruction cycle model
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   // pin synchroniser, then edge detect on the second stage
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pin_s1_q   <= 1'b0;
         pin_s2_q   <= 1'b0;
         pin_prev_q <= 1'b0;
      end else begin
         pin_s1_q   <= i_ext_count_input;
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   assign pin_edge = edge_sel ? (pin_prev_q & ~pin_s2_q)
                              : (~pin_prev_q & pin_s2_q);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wd_prev_q <= 1'b0;
      end else begin
         wd_prev_q <= i_watchdog_tick;
      end
   end

   // prescaler input: counting edge for the timer, tick for the watchdog
   always_comb begin
      if (to_watchdog) begin
         ps_step = i_watchdog_tick & ~wd_prev_q;
      end else if (src_sel) begin
         ps_step = pin_edge;
      end else begin
         ps_step = (phase_q == tmr_pkg::PHASE_FOUR);
      end
   end

   assign ps_clear = (!to_watchdog && count_wr) ||
                     (to_watchdog && i_watchdog_clear_instr);

   prescale_ripple #(
      .WIDTH (tmr_pkg::PRESCALE_W)
   ) u_prescale (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_clear (ps_clear),
      .i_step  (ps_step),
      .o_count (ps_count)
   );

   // bit n of the chain divides by 2^(n+1)
   assign ps_out = ps_count[ratio];

   always_comb begin
      if (to_watchdog) begin
         src_level = src_sel ? pin_s2_q : phase_q[1];
      end else begin
         src_level = ps_out;
      end
   end

   assign wd_out = to_watchdog ? ps_out : i_watchdog_tick;

   // sample the divided level only in phases two and four
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         samp_q      <= 1'b0;
         samp_prev_q <= 1'b0;
      end else if (phase_q == tmr_pkg::PHASE_TWO ||
                   phase_q == tmr_pkg::PHASE_FOUR) begin
         samp_q      <= src_level;
         samp_prev_q <= samp_q;
      end
   end

   always_comb begin
      if (to_watchdog && src_sel) begin
         inc_event = pin_edge;
      end else if (to_watchdog) begin
         inc_event = (phase_q == tmr_pkg::PHASE_FOUR);
      end else begin
         // one increment per rising edge of the divided level
         inc_event = (phase_q == tmr_pkg::PHASE_FOUR ||
                      phase_q == tmr_pkg::PHASE_TWO) &&
                     samp_q && !samp_prev_q;
      end
   end

   // count register, no reset so the value survives resets
   always_ff @(posedge i_clk) begin
      if (count_wr) begin
         count_q <= i_reg_wdata;
      end else if (inc_event && inhibit_q == 2'h0) begin
         count_q <= count_q + 8'h01;
      end
   end

   // inhibit window measured in instruction cycles
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         inhibit_q <= 2'h0;
      end else if (count_wr) begin
         inhibit_q <= 2'(tmr_pkg::INHIBIT_CYCLES);
      end else if (inhibit_q != 2'h0 &&
                   phase_q == tmr_pkg::PHASE_FOUR) begin
         inhibit_q <= inhibit_q - 2'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_reg_rdata        <= 8'h00;
         o_watchdog_timeout <= 1'b0;
      end else begin
         o_reg_rdata        <= count_q;
         o_watchdog_timeout <= wd_out;
      end
   end
endmodule

/* File: hdl/tmr_pkg.sv */
// constants for the timer with shared prescaler
// Function
// - eight-bit count register, readable and writable by software
// - source select clear: timer mode, one increment per instruction cycle while the prescaler serves the watchdog
// - count write suppresses incrementing for the two following cycles
// - source select set: count edges of the external count input
// - edge select bit: clear counts rising, set counts falling edges
// - prescaler serves timer or watchdog exclusively, never both
// - assignment bit clear routes prescaler to the timer
// - timer ratios 1:2 to 1:256 in power-of-two steps
// - prescaler is an eight-bit counter, pre- or post-divider
// - prescaler count has no software read or write path
// - count writes clear prescaler while it serves the timer
// - watchdog clear clears prescaler while it serves the watchdog
// - any reset forces every prescaler bit to zero
// - count register keeps its value across reset
// - without timer prescaler, pin goes straight to the synchroniser
// - prescaler output sampled in phases two and four
// - timer prescaler divides the external input as a ripple chain; the code steps it on synchronised pin edges, clocked by i_clk
// - increment follows only after synchronised output propagates
package tmr_pkg;
   localparam logic [6:0] TIMER_COUNT_ADDR = 7'h01;
   localparam logic [5:0] CONFIG_RESET     = 6'h3F;
   localparam int         SRC_SEL_BIT      = 5;
   localparam int         EDGE_SEL_BIT     = 4;
   localparam int         ASSIGN_BIT       = 3;
   localparam int         RATIO_MSB        = 2;
   localparam int         PRESCALE_W       = 8;
   localparam int         INHIBIT_CYCLES   = 2;
   localparam int         PHASES           = 4;
   localparam logic [1:0] PHASE_TWO        = 2'h1;
   localparam logic [1:0] PHASE_FOUR       = 2'h3;
endpackage

/* File: hdl/prescale_ripple.sv */
// eight-stage divide-by-two chain of the shared prescaler
`timescale 1ns/1ps
module prescale_ripple #(
   parameter int WIDTH = tmr_pkg::PRESCALE_W
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_clear,
   input  wire logic             i_step,
   output logic      [WIDTH-1:0] o_count
);
   initial begin
      if (WIDTH < 1) $error("prescaler width must be positive");
   end

   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH:0]   carry;

   assign carry[0] = i_step;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_stage
         // each stage toggles when all lower stages roll over
         assign carry[g+1] = carry[g] & cnt_q[g];
         always_ff @(posedge i_clk) begin
            if (!i_rst_n || i_clear) begin
               cnt_q[g] <= 1'b0;
            end else if (carry[g]) begin
               cnt_q[g] <= ~cnt_q[g];
            end
         end
      end
   endgenerate

   assign o_count = cnt_q;
endmodule

/* File: verification/timer_with_shared_prescaler_properties.sv */
// port-level assertions for the timer with shared prescaler
`timescale 1ns/1ps
module timer_with_shared_prescaler_properties (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic [6:0] i_reg_addr,
   input  wire logic       i_reg_wr,
   input  wire logic [7:0] i_reg_wdata,
   input  wire logic [7:0] o_reg_rdata,
   input  wire logic       i_config_wr,
   input  wire logic [5:0] i_config_wdata,
   input  wire logic       i_watchdog_clear_instr,
   input  wire logic       i_watchdog_tick,
   input  wire logic       i_ext_count_input,
   input  wire logic       o_watchdog_timeout
);
   logic [5:0] cfg_q;
   logic       cw;
   assign cw = i_reg_wr && i_reg_addr == tmr_pkg::TIMER_COUNT_ADDR;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) cfg_q <= tmr_pkg::CONFIG_RESET;
      else if (i_config_wr) cfg_q <= i_config_wdata;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_write;
      cw ##1 !cw;
   endsequence
   sequence s_quiet;
      (!cw)[*4];
   endsequence
   a_write_visible: assert property (s_write |=>
      o_reg_rdata == $past(i_reg_wdata, 2)) else $error("write lost");
   a_inhibit_hold: assert property (cw ##1 s_quiet |->
      o_reg_rdata == $past(i_reg_wdata, 4)) else $error("no inhibit");
   a_step_one: assert property ($past(i_rst_n, 2) && $past(i_rst_n)
      && !$past(cw, 2) && $changed(o_reg_rdata) |->
      o_reg_rdata == $past(o_reg_rdata) + 8'h01) else $error("bad step");
   a_timer_spacing: assert property (!cfg_q[5] && $changed(o_reg_rdata)
      |=> (!$changed(o_reg_rdata) || $past(cw, 2))[*3])
      else $error("timer too fast");
   a_pin_quiet: assert property (($stable(i_ext_count_input)
      && cfg_q[5] && !cw)[*8] |-> !$changed(o_reg_rdata))
      else $error("count without edge");
   a_tick_pass: assert property (!cfg_q[3] && !$past(cfg_q[3])
      && $past(i_rst_n) |-> o_watchdog_timeout == $past(i_watchdog_tick))
      else $error("watchdog not undivided");
   a_wdt_clear: assert property ((i_watchdog_clear_instr && cfg_q[3]
      && !i_watchdog_tick) ##1 !i_watchdog_tick |=> !o_watchdog_timeout)
      else $error("clear missed prescaler");
   a_reset_clear: assert property ($rose(i_rst_n) |->
      !o_watchdog_timeout && o_reg_rdata == 8'h00) else $error("reset");
endmodule
bind timer_with_shared_prescaler timer_with_shared_prescaler_properties
   i_props (.*);

/* File: verification/count_pin_model.sv */
// external count pin source
`timescale 1ns/1ps
module count_pin_model (
   input  wire logic i_clk,
   output logic      o_pin
);
   initial o_pin = 1'b0;
   task automatic set_level(input logic lvl);
      o_pin = lvl;
      repeat (8) @(negedge i_clk);
   endtask
endmodule

/* File: verification/timer_with_shared_prescaler_tb.sv */
// self-checking bench for the timer with shared prescaler
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin \
   miscompares++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module timer_with_shared_prescaler_tb;
   logic       clk, rst_n, wr, cwr, wdc, tick, pin, wto;
   logic [6:0] addr;
   logic [7:0] wd, rd;
   logic [5:0] cfg;
   int         miscompares = 0;
   int         n_tests = 0;
   timer_with_shared_prescaler i_dut (.i_clk(clk), .i_rst_n(rst_n),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd), .o_reg_rdata(rd),
      .i_config_wr(cwr), .i_config_wdata(cfg), .i_watchdog_clear_instr(wdc),
      .i_watchdog_tick(tick), .i_ext_count_input(pin),
      .o_watchdog_timeout(wto));
   count_pin_model i_pin (.i_clk(clk), .o_pin(pin));
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr_cfg(input logic [5:0] c);
      cfg = c;
      cwr = 1'b1;
      step(1);
      cwr = 1'b0;
   endtask
   task automatic wr_count(input logic [7:0] d);
      wd = d;
      wr = 1'b1;
      step(1);
      wr = 1'b0;
   endtask
   task automatic clear_wdog();
      wdc = 1'b1;
      step(1);
      wdc = 1'b0;
      step(2);
   endtask
   task automatic t_count();
      logic [7:0] r;
      wr_cfg(6'h08);
      wr_count(8'hA5);
      step(1);
      `CHK(rd, 8'hA5)
      step(3);
      `CHK(rd, 8'hA5)
      step(10);
      r = rd;
      step(40);
      `CHK(rd - r, 8'h0A)
   endtask
   task automatic t_ratio();
      logic [7:0] r;
      for (int k = 0; k < 8; k++) begin
         wr_cfg({3'b000, k[2:0]});
         wr_count(8'h00);
         step(20);
         r = rd;
         step(32 << k);
         `CHK(rd - r, 8'h04)
      end
   endtask
   task automatic t_edge();
      logic [7:0] r;
      for (int f = 0; f < 2; f++) begin
         wr_cfg({1'b1, f[0], 4'h8});
         i_pin.set_level(1'b0);
         r = rd;
         i_pin.set_level(1'b1);
         `CHK(rd - r, f ? 8'h00 : 8'h01)
         i_pin.set_level(1'b0);
         `CHK(rd - r, 8'h01)
      end
   endtask
   task automatic t_wdog();
      wr_cfg(6'h00);
      clear_wdog();
      wr_count(8'h00);
      wr_cfg(6'h0F);
      clear_wdog();
      wr_cfg(6'h08);
      clear_wdog();
      `CHK(wto, 1'b0)
      tick = 1'b1;
      step(3);
      `CHK(wto, 1'b1)
      clear_wdog();
      `CHK(wto, 1'b0)
      tick = 1'b0;
      wr_cfg(6'h00);
      step(2);
      `CHK(wto, 1'b0)
      tick = 1'b1;
      step(2);
      `CHK(wto, 1'b1)
   endtask
   task automatic t_reset();
      tick = 1'b0;
      wr_count(8'h5C);
      step(3);
      rst_n = 1'b0;
      step(2);
      rst_n = 1'b1;
      step(2);
      `CHK(rd, 8'h5C)
   endtask
   task automatic conclude();
      if (miscompares == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      {rst_n, wr, cwr, wdc, tick} = '0;
      addr = 7'h01;
      wd = 8'h00;
      cfg = 6'h00;
      step(2);
      rst_n = 1'b1;
      t_count();
      t_ratio();
      t_edge();
      t_wdog();
      t_reset();
      conclude();
   end
   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      conclude();
   end
endmodule
